// [verilog/modem_flow_control.sv]
// Purpose: out-of-band flow control, modem pins and change detection, one channel
// Assumes: APB slave on pclk, fifo and transmitter logic on the same clock
// Notes: modem pins are active low; register bits are in asserted sense

`timescale 1ns/1ps
`default_nettype none

module modem_flow_control #(
	parameter int unsigned scan_cycles = modem_flow_pkg::SCAN_CYCLES // scan pass length
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [modem_flow_pkg::ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire logic cts_n_pin, // clear to send pin
	input wire logic dsr_n_pin, // data set ready pin
	input wire logic cd_n_pin, // carrier detect pin
	input wire logic ri_n_pin, // ring indicator pin
	input wire logic dtr_function_select, // static: high makes dtr pin an output
	output logic rts_n_out, // request to send pin
	input wire logic dtr_n_in, // dtr pin level in
	output logic dtr_n_out, // dtr pin level out
	output logic dtr_n_oe, // dtr pin driven when high
	output logic modem_irq_out_n, // modem change interrupt, active low
	input wire modem_flow_pkg::tx_side_type tx_side, // transmitter status
	output logic tx_load_grant, // fifo may move a character to holding
	output logic tx_special_grant, // special character may go out
	input wire modem_flow_pkg::rx_side_type rx_side, // receiver status
	output logic rx_char_accept, // received character may enter the fifo
	output var modem_flow_pkg::flow_options_type flow_options // in-band enables
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	modem_flow_pkg::state_type state; // all registered state
	modem_flow_pkg::state_type next_state; // next value of it
	logic [modem_flow_pkg::NUM_INPUTS-1:0] live_level; // asserted sense, live
	logic [modem_flow_pkg::NUM_INPUTS-1:0] rise_edge; // off-to-on since last scan
	logic [modem_flow_pkg::NUM_INPUTS-1:0] fall_edge; // on-to-off since last scan
	logic [modem_flow_pkg::NUM_INPUTS-1:0] edge_hit; // enabled edges this scan
	logic scan_tick; // end of a scan pass
	logic [3:0] threshold; // rx_handshake_threshold
	logic dtr_auto; // threshold control owns dtr
	logic rts_auto; // transmit logic owns rts
	logic apb_setup; // setup phase of a transfer
	logic apb_write; // write takes effect this edge
	logic addr_ok; // address maps to a register
	logic [7:0] read_byte; // value for the addressed register
	logic [7:0] wbyte; // low byte of write data

	// ----------------------------------------------------------------
	// live input levels, inverted pin sense
	// ----------------------------------------------------------------
	// the cd bit comes from the dtr pin when that pin is not an output
	always_comb begin
		live_level = ~state.in_sync;
		if (!state.dsel_sync) begin
			live_level[modem_flow_pkg::IN_CD] = ~state.dtr_in_sync;
		end
	end

	// ----------------------------------------------------------------
	// per-input edge detection against the last scan
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < modem_flow_pkg::NUM_INPUTS; gi++) begin : g_edge
			// compare live level with the copy from the previous pass
			assign rise_edge[gi] = live_level[gi] & ~state.scan_prev[gi];
			assign fall_edge[gi] = ~live_level[gi] & state.scan_prev[gi];
			assign edge_hit[gi] = scan_tick & (
				(rise_edge[gi] & state.change_opt1[modem_flow_pkg::EDGE_LSB + gi]) |
				(fall_edge[gi] & state.change_opt2[modem_flow_pkg::EDGE_LSB + gi]));
		end
	endgenerate

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// scan tick is free running; a slower pass costs latency, and a change undone within one pass is missed
	assign scan_tick = (32'(state.scan_count) == scan_cycles - 1);
	assign threshold = state.change_opt1[modem_flow_pkg::THRESH_LSB +: 4];
	assign dtr_auto = (threshold != 4'h0) && rx_side.enable;
	assign rts_auto = state.option2[modem_flow_pkg::BIT_AUTO_RTS];
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pwrite && ce;
	assign wbyte = pwdata[7:0];

	// address decode and read mux
	always_comb begin
		addr_ok = 1'b1;
		read_byte = 8'h00;
		case (paddr)
			modem_flow_pkg::OFS_OPTION2: begin
				read_byte = state.option2;
			end
			modem_flow_pkg::OFS_OPTION3: begin
				read_byte = state.option3;
			end
			modem_flow_pkg::OFS_CHANGE_OPT1: begin
				read_byte = state.change_opt1;
			end
			modem_flow_pkg::OFS_CHANGE_OPT2: begin
				read_byte = state.change_opt2;
			end
			modem_flow_pkg::OFS_SIGNAL1, modem_flow_pkg::OFS_SIGNAL2: begin
				// both value registers show the live inputs and the driven outputs
				read_byte = {live_level, 2'b00, ~state.dtr_n, ~state.rts_n};
			end
			modem_flow_pkg::OFS_CHANGE: begin
				read_byte = {state.change, 4'h0};
			end
			modem_flow_pkg::OFS_IRQ_ENABLE: begin
				read_byte = state.irq_enable;
			end
			default: begin
				addr_ok = 1'b0; // unmapped reads zero and errors
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		if (ce) begin
			// two-stage synchronisers for every pin and the strap
			next_state.in_meta = {ri_n_pin, cd_n_pin, dsr_n_pin, cts_n_pin};
			next_state.in_sync = state.in_meta;
			next_state.dsel_meta = dtr_function_select;
			next_state.dsel_sync = state.dsel_meta;
			next_state.dtr_in_meta = dtr_n_in;
			next_state.dtr_in_sync = state.dtr_in_meta;

			// free-running scan timer, copy of levels kept per pass
			if (scan_tick) begin
				next_state.scan_count = '0;
				next_state.scan_prev = live_level;
			end else begin
				next_state.scan_count = state.scan_count + 1'b1;
			end

			// read data captured in setup so it leaves a flop
			if (apb_setup) begin
				next_state.prdata = read_byte;
				next_state.bad_addr = !addr_ok;
			end

			// register writes on the access edge
			if (apb_write) begin
				case (paddr)
					modem_flow_pkg::OFS_OPTION2: begin
						next_state.option2 = wbyte;
					end
					modem_flow_pkg::OFS_OPTION3: begin
						next_state.option3 = wbyte;
					end
					modem_flow_pkg::OFS_CHANGE_OPT1: begin
						next_state.change_opt1 = wbyte;
					end
					modem_flow_pkg::OFS_CHANGE_OPT2: begin
						next_state.change_opt2 = wbyte;
					end
					modem_flow_pkg::OFS_SIGNAL1: begin
						next_state.signal1 = wbyte;
					end
					modem_flow_pkg::OFS_SIGNAL2: begin
						next_state.signal2 = wbyte;
					end
					modem_flow_pkg::OFS_CHANGE: begin
						next_state.change = state.change & ~wbyte[7:4];
					end
					modem_flow_pkg::OFS_IRQ_ENABLE: begin
						next_state.irq_enable = wbyte;
					end
					default: begin
						next_state.option2 = state.option2; // unmapped write ignored
					end
				endcase
			end

			// a detected edge wins over a clear in the same cycle
			next_state.change = next_state.change | edge_hit;

			// interrupt request from flags and enable
			next_state.irq_n = !((|next_state.change) &&
				next_state.irq_enable[modem_flow_pkg::BIT_MODEM_IRQ_EN]);

			// rts: pending transmit data, or the manual bit
			if (rts_auto) begin
				next_state.rts_n = !((tx_side.fifo_count != 4'h0) || tx_side.busy);
			end else begin
				next_state.rts_n = !state.signal1[modem_flow_pkg::BIT_RTS_MANUAL];
			end

			// dtr: receive threshold, or the manual bit
			if (dtr_auto) begin
				next_state.dtr_n = !(rx_side.fifo_count < threshold);
			end else begin
				next_state.dtr_n = !state.signal2[modem_flow_pkg::BIT_DTR_MANUAL];
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// pins idle deasserted (high) and irq idle high out of reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
			state.rts_n <= 1'b1;
			state.dtr_n <= 1'b1;
			state.irq_n <= 1'b1;
			state.in_meta <= '1;
			state.in_sync <= '1;
			state.dtr_in_meta <= 1'b1;
			state.dtr_in_sync <= 1'b1;
			state.dsel_meta <= 1'b1;
			state.dsel_sync <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata = {24'h000000, state.prdata};
	assign pready = ce; // zero wait states while enabled
	assign pslverr = psel && penable && ce && state.bad_addr;
	assign rts_n_out = state.rts_n;
	assign dtr_n_out = state.dtr_n;
	assign dtr_n_oe = state.dsel_sync;
	assign modem_irq_out_n = state.irq_n;
	// cts checked live only at the fifo to holding move; holding and shift drain
	assign tx_load_grant = tx_side.load_req && ce &&
		(!state.option2[modem_flow_pkg::BIT_CTS_GATE] || live_level[modem_flow_pkg::IN_CTS]);
	assign tx_special_grant = tx_side.special_req && ce;
	assign rx_char_accept = rx_side.char_valid && ce &&
		(!state.option2[modem_flow_pkg::BIT_DSR_GATE] || live_level[modem_flow_pkg::IN_DSR]);
	// in-band enables are only held here; the character logic acts on them
	assign flow_options = '{
		tx_inband: state.option2[modem_flow_pkg::BIT_TX_INBAND],
		implied_resume: state.option2[modem_flow_pkg::BIT_IMPLIED_RESUME],
		char_detect: state.option3[modem_flow_pkg::BIT_CHAR_DETECT],
		transparency: state.option3[modem_flow_pkg::BIT_TRANSPARENCY]};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	dtr_auto_on_a: assert property ((ce && dtr_auto && rx_side.fifo_count < threshold)
		|=> !dtr_n_out) else $error("dtr not asserted below threshold");

	dtr_auto_off_a: assert property ((ce && dtr_auto && rx_side.fifo_count >= threshold)
		|=> dtr_n_out) else $error("dtr not deasserted at threshold");

	dtr_manual_a: assert property ((ce && threshold == 4'h0)
		|=> dtr_n_out == !$past(state.signal2[modem_flow_pkg::BIT_DTR_MANUAL]))
		else $error("manual dtr not followed");

	dsr_gate_a: assert property ((rx_side.char_valid &&
		state.option2[modem_flow_pkg::BIT_DSR_GATE] && state.in_sync[modem_flow_pkg::IN_DSR])
		|-> !rx_char_accept) else $error("character kept while dsr off");

	rts_auto_a: assert property ((ce && rts_auto && tx_side.fifo_count == 4'h0 && !tx_side.busy)
		|=> rts_n_out) else $error("rts not dropped when idle");

	cts_gate_a: assert property ((tx_load_grant && state.option2[modem_flow_pkg::BIT_CTS_GATE])
		|-> !state.in_sync[modem_flow_pkg::IN_CTS]) else $error("load granted without cts");

	special_send_a: assert property ((ce && tx_side.special_req)
		|-> tx_special_grant) else $error("special character blocked");

	change_flag_a: assert property ((ce && |edge_hit)
		|=> ((state.change & $past(edge_hit)) == $past(edge_hit)) &&
		(modem_irq_out_n == !state.irq_enable[modem_flow_pkg::BIT_MODEM_IRQ_EN]))
		else $error("edge flag or interrupt missing");

	scan_bound_a: assert property (32'(state.scan_count) < scan_cycles)
		else $error("scan counter past its period");

	level_read_a: assert property ((ce && apb_setup && paddr == modem_flow_pkg::OFS_SIGNAL1)
		|=> prdata[7:4] == $past(live_level)) else $error("signal value readback wrong");

	// positive sides of the rts and dsr gates, so a stuck-off output is caught too; then the interrupt mask
	rts_busy_a: assert property ((ce && rts_auto && (tx_side.fifo_count != 4'h0 || tx_side.busy))
		|=> !rts_n_out) else $error("rts not raised with data pending");

	rts_manual_a: assert property ((ce && !rts_auto)
		|=> rts_n_out == !$past(state.signal1[modem_flow_pkg::BIT_RTS_MANUAL]))
		else $error("manual rts not followed");

	dsr_pass_a: assert property ((ce && rx_side.char_valid && !state.in_sync[modem_flow_pkg::IN_DSR])
		|-> rx_char_accept) else $error("character dropped while dsr on");

	irq_mask_a: assert property (!state.irq_enable[modem_flow_pkg::BIT_MODEM_IRQ_EN]
		|-> modem_irq_out_n) else $error("interrupt raised while masked");

	// clock enable low stalls the bus and closes every handshake
	ce_hold_a: assert property (!ce
		|-> !tx_load_grant && !tx_special_grant && !rx_char_accept && !pready)
		else $error("grant or ready while clock enable low");

endmodule

`default_nettype wire

// [verilog/modem_flow_pkg.sv]
// Purpose: constants and carrier types for the modem flow-control block
// Assumes: 40 MHz pclk, APB register access, 8-bit registers in low data bits
// Notes: all offsets are byte addresses on the APB bus

package modem_flow_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_OPTION2 = 8'h00; // channel_option_reg_2
	localparam logic [7:0] OFS_OPTION3 = 8'h04; // channel_option_reg_3
	localparam logic [7:0] OFS_CHANGE_OPT1 = 8'h08; // modem_change_option_1
	localparam logic [7:0] OFS_CHANGE_OPT2 = 8'h0C; // modem_change_option_2
	localparam logic [7:0] OFS_SIGNAL1 = 8'h10; // modem_signal_value_1
	localparam logic [7:0] OFS_SIGNAL2 = 8'h14; // modem_signal_value_2
	localparam logic [7:0] OFS_CHANGE = 8'h18; // modem change flags, write one to clear
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C; // modem interrupt enable
	localparam logic [7:0] RESET_BYTE = 8'h00; // every register resets to zero

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_DSR_GATE = 0; // option2: dsr_rx_gate_enable
	localparam int BIT_CTS_GATE = 1; // option2: cts_tx_gate_enable
	localparam int BIT_AUTO_RTS = 2; // option2: auto_rts_output_enable
	localparam int BIT_TX_INBAND = 6; // option2: auto_tx_inband_enable
	localparam int BIT_IMPLIED_RESUME = 7; // option2: implied_resume_mode
	localparam int BIT_CHAR_DETECT = 4; // option3: flow_char_detect_enable
	localparam int BIT_TRANSPARENCY = 5; // option3: flow_char_transparency
	localparam int BIT_RTS_MANUAL = 0; // signal1: rts value
	localparam int BIT_DTR_MANUAL = 1; // signal2: dtr value
	localparam int BIT_MODEM_IRQ_EN = 0; // irq enable register
	localparam int THRESH_LSB = 0; // change_opt1: rx_handshake_threshold [3:0]
	localparam int EDGE_LSB = 4; // edge enables / flags / input levels at [7:4]
	localparam int NUM_INPUTS = 4; // cts, dsr, cd, ri
	localparam int IN_CTS = 0;
	localparam int IN_DSR = 1;
	localparam int IN_CD = 2;
	localparam int IN_RI = 3;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000; // 40 MHz
	localparam int SCAN_PERIOD_US = 1000; // one scan pass, worst latency one pass plus synchroniser cycles
	localparam int SCAN_CYCLES = (SCAN_PERIOD_US * 1000000) / CLK_PERIOD_PS;
	localparam int SCAN_CNT_W = 16;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] fifo_count; // characters in transmit fifo
		logic busy; // shift or holding register occupied
		logic load_req; // fifo wants to move a character to holding
		logic special_req; // special character waiting to go out
	} tx_side_type;

	typedef struct packed {
		logic [3:0] fifo_count; // characters in receive fifo
		logic enable; // receiver enabled
		logic char_valid; // one-cycle pulse, a character was received
	} rx_side_type;

	typedef struct packed {
		logic tx_inband; // auto transmit in-band control
		logic implied_resume; // any character resumes transmit
		logic char_detect; // special characters 1 and 2 recognised
		logic transparency; // flow characters kept from the fifo
	} flow_options_type;

	typedef struct packed {
		logic [NUM_INPUTS-1:0] in_meta; // first synchroniser stage
		logic [NUM_INPUTS-1:0] in_sync; // second stage, raw pin levels
		logic dsel_meta;
		logic dsel_sync;
		logic dtr_in_meta;
		logic dtr_in_sync;
		logic [7:0] option2;
		logic [7:0] option3;
		logic [7:0] change_opt1;
		logic [7:0] change_opt2;
		logic [7:0] signal1;
		logic [7:0] signal2;
		logic [NUM_INPUTS-1:0] change;
		logic [7:0] irq_enable;
		logic [SCAN_CNT_W-1:0] scan_count;
		logic [NUM_INPUTS-1:0] scan_prev;
		logic [7:0] prdata;
		logic bad_addr;
		logic rts_n;
		logic dtr_n;
		logic irq_n;
	} state_type;

endpackage

// [testbench/remote_modem.sv]
// Purpose: remote modem model on the handshake lines
// Assumes: bench commands line levels in asserted sense
// Notes: cts may track rts after a lag, like a slow remote
`timescale 1ns/1ps
`default_nettype none
module remote_modem #(
	parameter int lag = 3 // cts follows rts lag plus one cycles later when tracking
) (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic [3:0] line_cmd, // ri cd dsr cts, one = asserted
	input wire logic follow_rts, // cts tracks rts instead of line_cmd
	input wire logic rts_n_line, // request to send from the device
	output logic cts_n, // clear to send
	output logic dsr_n, // data set ready
	output logic cd_n, // carrier detect
	output logic ri_n // ring indicator
);
	int wait_cnt; // rts to cts lag count
	// lines idle high out of reset; low means asserted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ri_n, cd_n, dsr_n, cts_n} <= 4'hF;
			wait_cnt <= 0;
		end else begin
			{ri_n, cd_n, dsr_n} <= ~line_cmd[3:1];
			if (!follow_rts) begin
				cts_n <= ~line_cmd[0];
			end else if (rts_n_line) begin
				cts_n <= 1'b1; // drop at once, grant only after lag
				wait_cnt <= 0;
			end else if (wait_cnt < lag) begin
				wait_cnt <= wait_cnt + 1;
			end else begin
				cts_n <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/modem_flow_control_tb.sv]
// Purpose: self-checking bench for the modem flow-control block
// Assumes: short scan pass of 16 cycles, dtr strap dropped once for the cd remap
// Notes: expectations come from small integer models below
`timescale 1ns/1ps
`default_nettype none
module modem_flow_control_tb;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, rts_n, dtr_n, dtr_oe, irq_n, ld_g, sp_g, acc;
	logic cts_n, dsr_n, cd_n, ri_n, follow = 0, dsel = 1, ext_dtr = 1, en = 1;
	logic [3:0] cmd = 4'h0, fo_exp;
	wire logic dtr_line; // driven by ext_dtr when the device releases it
	modem_flow_pkg::tx_side_type tx = '0;
	modem_flow_pkg::rx_side_type rx = '0;
	modem_flow_pkg::flow_options_type fo;
	int err_total = 0, cmp_count = 0, cyc = 0, t, c, v, b;
	int regv[4];
	int thr[4] = '{0, 1, 5, 12};
	integer seed = 32'hc699e1a8;
	assign dtr_line = dtr_oe ? dtr_n : ext_dtr;
	always #12.5 pclk = ~pclk;
	// ------------------------------------------------------------
	// design and remote
	// ------------------------------------------------------------
	modem_flow_control #(.scan_cycles(16)) i_dut (.pclk(pclk), .presetn(presetn), .ce(en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n_pin(cts_n),
		.dsr_n_pin(dsr_n), .cd_n_pin(cd_n), .ri_n_pin(ri_n), .dtr_function_select(dsel),
		.rts_n_out(rts_n), .dtr_n_in(dtr_line), .dtr_n_out(dtr_n), .dtr_n_oe(dtr_oe),
		.modem_irq_out_n(irq_n), .tx_side(tx), .tx_load_grant(ld_g),
		.tx_special_grant(sp_g), .rx_side(rx), .rx_char_accept(acc), .flow_options(fo));
	remote_modem i_far (.pclk(pclk), .presetn(presetn), .line_cmd(cmd), .follow_rts(follow),
		.rts_n_line(rts_n), .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n), .ri_n(ri_n));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; waits for pready, takes data at that edge
	task automatic apb(input logic [7:0] a, input logic w, input int d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= 32'(d & 255);
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	// models: one means pin high, deasserted
	function automatic logic dtr_m(int th, int n, int en, int man);
		if (th != 0 && en != 0) begin
			return n >= th;
		end
		return man == 0;
	endfunction
	function automatic logic rts_m(int au, int n, int bz, int man);
		if (au != 0) begin
			return !(n != 0 || bz != 0);
		end
		return man == 0;
	endfunction
	task automatic wrap_up;
		if (err_total == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// hang guard, the full run needs about 700 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		chk("rts_n reset", rts_n, 1);
		chk("dtr_n reset", dtr_n, 1);
		chk("irq_n reset", irq_n, 1);
		for (v = 0; v < 8; v++) begin
			apb(8'(4 * v), 0, 0);
			chk("reset reg", rd, 0);
		end
		apb(8'h20, 1, 255);
		chk("slverr write", er, 1);
		apb(8'h20, 0, 0);
		chk("unmapped read", {rd[30:0], er}, 1);
		// option and change-option storage, random contents
		for (v = 0; v < 4; v++) begin
			regv[v] = $random(seed) & 255;
			apb(8'(4 * v), 1, regv[v]);
			apb(8'(4 * v), 0, 0);
			chk("reg store", rd, regv[v]);
		end
		fo_exp = {regv[0][6], regv[0][7], regv[1][4], regv[1][5]};
		chk("flow options", fo, fo_exp);
		// manual outputs, inverted sense
		apb(modem_flow_pkg::OFS_OPTION2, 1, 0);
		apb(modem_flow_pkg::OFS_CHANGE_OPT1, 1, 0);
		apb(modem_flow_pkg::OFS_SIGNAL1, 1, 1);
		apb(modem_flow_pkg::OFS_SIGNAL2, 1, 2);
		settle(1);
		chk("manual rts", rts_n, 0);
		chk("manual dtr", dtr_n, 0);
		apb(modem_flow_pkg::OFS_SIGNAL1, 0, 0);
		chk("out readback", rd[1:0], 3);
		// auto dtr against receive count
		apb(modem_flow_pkg::OFS_SIGNAL2, 1, 0);
		@(posedge pclk);
		rx.enable <= 1'b1;
		for (t = 0; t < 4; t++) begin
			apb(modem_flow_pkg::OFS_CHANGE_OPT1, 1, thr[t]);
			for (c = 12; c >= 0; c--) begin
				@(posedge pclk);
				rx.fifo_count <= 4'(c);
				settle(1);
				chk("auto dtr", dtr_n, dtr_m(thr[t], c, 1, 0));
			end
		end
		@(posedge pclk);
		rx.enable <= 1'b0;
		settle(1);
		chk("dtr rx off", dtr_n, dtr_m(12, 0, 0, 0));
		// auto rts with random transmit occupancy
		apb(modem_flow_pkg::OFS_OPTION2, 1, 4);
		apb(modem_flow_pkg::OFS_SIGNAL1, 1, 0);
		for (t = 0; t < 12; t++) begin
			v = $random(seed) & 31;
			c = (v & 15) % 13;
			b = v >> 4;
			@(posedge pclk);
			tx.fifo_count <= 4'(c);
			tx.busy <= b[0];
			settle(1);
			chk("auto rts", rts_n, rts_m(1, c, b, 0));
		end
		// cts gate with a slow remote tracking rts
		apb(modem_flow_pkg::OFS_OPTION2, 1, 6);
		@(posedge pclk);
		tx <= '{4'h0, 1'b0, 1'b1, 1'b1};
		follow <= 1'b1;
		settle(6);
		chk("load held", ld_g, 0);
		chk("special free", sp_g, 1);
		@(posedge pclk);
		tx.fifo_count <= 4'h3;
		t = 0;
		while (ld_g !== 1'b1 && t < 30) begin
			@(negedge pclk);
			t++;
		end
		chk("grant lag", t > 3 && t < 12, 1);
		@(posedge pclk);
		tx.fifo_count <= 4'h0;
		settle(5);
		chk("grant drop", ld_g, 0);
		apb(modem_flow_pkg::OFS_OPTION2, 1, 4);
		settle(1);
		chk("gate off", ld_g, 1);
		// clock enable low: grants close, rts holds until it returns
		@(posedge pclk);
		en <= 1'b0;
		tx.fifo_count <= 4'h5;
		settle(2);
		chk("ce grants", {pready, ld_g, sp_g}, 0);
		chk("ce freeze", rts_n, 1);
		@(posedge pclk);
		en <= 1'b1;
		settle(1);
		chk("ce resume", rts_n, 0);
		// dsr gate and live readback over every input pattern
		apb(modem_flow_pkg::OFS_OPTION2, 1, 1);
		@(posedge pclk);
		follow <= 1'b0;
		for (v = 0; v < 16; v++) begin
			@(posedge pclk);
			cmd <= 4'(v);
			settle(3);
			@(posedge pclk);
			rx.char_valid <= 1'b1;
			@(negedge pclk);
			chk("dsr gate", acc, v >> 1 & 1);
			@(posedge pclk);
			rx.char_valid <= 1'b0;
			apb(modem_flow_pkg::OFS_SIGNAL1, 0, 0);
			chk("live inputs", rd[7:4], v);
		end
		// strap low: dtr pin released and read back as the cd bit
		@(posedge pclk);
		cmd <= 4'h0;
		dsel <= 1'b0;
		ext_dtr <= 1'b0;
		settle(3);
		chk("dtr released", dtr_oe, 0);
		apb(modem_flow_pkg::OFS_SIGNAL1, 0, 0);
		chk("cd from dtr", rd[7:4], 4'h4);
		@(posedge pclk);
		dsel <= 1'b1;
		ext_dtr <= 1'b1;
		settle(3);
		chk("dtr driven", dtr_oe, 1);
		// change detection, flags, interrupt, mask
		@(posedge pclk);
		cmd <= 4'h0;
		settle(40);
		apb(modem_flow_pkg::OFS_CHANGE_OPT1, 1, 8'h80);
		apb(modem_flow_pkg::OFS_CHANGE_OPT2, 1, 0);
		apb(modem_flow_pkg::OFS_IRQ_ENABLE, 1, 1);
		apb(modem_flow_pkg::OFS_CHANGE, 1, 8'hF0);
		settle(1);
		chk("irq idle", irq_n, 1);
		@(posedge pclk);
		cmd <= 4'h8;
		t = 0;
		while (irq_n !== 1'b0 && t < 40) begin
			@(negedge pclk);
			t++;
		end
		chk("irq raised", irq_n, 0);
		apb(modem_flow_pkg::OFS_CHANGE, 0, 0);
		chk("ri flag", rd, 8'h80);
		apb(modem_flow_pkg::OFS_CHANGE, 1, 8'h80);
		settle(1);
		chk("irq cleared", irq_n, 1);
		@(posedge pclk);
		cmd <= 4'h0;
		settle(40);
		apb(modem_flow_pkg::OFS_CHANGE, 0, 0);
		chk("edge disabled", rd, 0);
		apb(modem_flow_pkg::OFS_IRQ_ENABLE, 1, 0);
		apb(modem_flow_pkg::OFS_CHANGE_OPT2, 1, 8'h10);
		@(posedge pclk);
		cmd <= 4'h1;
		settle(40);
		apb(modem_flow_pkg::OFS_CHANGE, 0, 0);
		chk("on edge off", rd, 0);
		@(posedge pclk);
		cmd <= 4'h0;
		settle(40);
		apb(modem_flow_pkg::OFS_CHANGE, 0, 0);
		chk("cts flag", rd, 8'h10);
		chk("irq masked", irq_n, 1);
		apb(modem_flow_pkg::OFS_IRQ_ENABLE, 1, 1);
		settle(2);
		chk("irq unmasked", irq_n, 0);
		wrap_up();
	end
endmodule
`default_nettype wire
